// File: verilog/uss_pkg_sync.sv
// constants for the synchronous-slave serial unit, and its input synchroniser
// assumes one system clock and a synchronous active-low reset
`timescale 1ns/1ns
`default_nettype none

package uss_pkg;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int WORD_BITS = 8;
    localparam int CNT_W = 3;
    localparam logic [CNT_W-1:0] LAST_BIT = 3'h7;

    localparam logic [ADDR_W-1:0] OFF_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_TXDATA   = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_RXDATA   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATUS   = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_IRQ_CLR  = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_IRQ_EN   = 8'h18;

    // control register fields
    localparam int CTRL_W     = 6;
    localparam int CTRL_SPEN  = 0;
    localparam int CTRL_SYNC  = 1;
    localparam int CTRL_SLAVE = 2;
    localparam int CTRL_TXEN  = 3;
    localparam int CTRL_CREN  = 4;
    localparam int CTRL_PERIPHERAL_IRQ_ENABLE  = 5;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // status register fields
    localparam int ST_RX_COMPLETE_FLAG   = 0;
    localparam int ST_TX_BUFFER_EMPTY_FLAG   = 1;
    localparam int ST_OVR    = 2;
    localparam int ST_BUSY   = 3;
    localparam int ST_SLEEP  = 4;
    localparam int ST_ACTIVE = 5;

    // event bits, shared by irq status, clear and enable
    localparam int EV_W   = 3;
    localparam int EV_RX  = 0;
    localparam int EV_TX  = 1;
    localparam int EV_OVR = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        USS_TX_IDLE  = 2'h0,
        USS_TX_SHIFT = 2'h1
    } uss_tx_state_t;
endpackage : uss_pkg

module uss_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : uss_sync

`default_nettype wire

// File: verilog/uss_top.sv
// synchronous-slave serial unit with sleep operation, axi4-lite registers
// assumes an external master drives the shift clock, idle low, slow vs aclk
`timescale 1ns/1ns
`default_nettype none

// Function
// R1 - In sleep the unit keeps shifting only when set up as synchronous slave.
// R2 - In any other mode nothing is shifted, since those modes need the system clock.
// R3 - In slave mode both shift registers advance only on the external shift clock.
// R4 - Firmware sets up slave reception before sleeping.
// R5 - Firmware reads the receive buffer before sleeping, clearing the receive flag.
// R6 - Firmware sets the receive, peripheral and global enables if it wants an interrupt.
// R7 - In slave reception data and clock are taken from the lines driven by the master.
// R8 - A complete word sets the receive-complete flag, which wakes the processor.
// R9 - Firmware fills the transmit buffer before sleeping, clearing the transmit flag.
// R10 - Firmware sets the transmit and peripheral enables to wake on transmission.
// R11 - In slave transmission the unit drives its shift data on the data line.
// R12 - After the last bit the buffered byte moves to the shifter and the flag sets.
// R13 - The buffer then takes a new character and writing it clears the flag.
// R14 - The transmit flag is read-only and set while enabled with the buffer empty.
// R15 - A set flag with its enable raises a wake request whether or not clocks run.
// R16 - Flags set in sleep are stable on wake and no flag event is lost.
module uss_top
    import uss_pkg::*;
(
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic      [1:0]        s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic      [DATA_W-1:0] s_axi_rdata,
    output logic      [1:0]        s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              sys_sleep,
    input  wire logic              serial_clock_line,
    input  wire logic              serial_data_line_in,
    output logic                   serial_data_line_out,
    output logic                   serial_data_line_oe_n,
    output logic                   wake_req,
    output logic                   irq
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
        reg_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : reg_hit

    function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
        reg_mapped = reg_hit(a, OFF_CTRL) || reg_hit(a, OFF_TXDATA) ||
                     reg_hit(a, OFF_RXDATA) || reg_hit(a, OFF_STATUS) ||
                     reg_hit(a, OFF_IRQ_STAT) || reg_hit(a, OFF_IRQ_CLR) ||
                     reg_hit(a, OFF_IRQ_EN);
    endfunction : reg_mapped

    logic                  sleep_s;
    logic                  sck_s;
    logic                  sdi_s;
    logic                  sck_prev_reg;
    logic                  sck_fall;
    logic [CTRL_W-1:0]     ctrl_reg;
    logic [EV_W-1:0]       irq_stat_reg;
    logic [EV_W-1:0]       irq_en_reg;
    logic                  mode_slave;
    logic                  rx_on;
    logic                  tx_on;
    logic [WORD_BITS-1:0]  rx_shift_reg;
    logic [WORD_BITS-1:0]  rx_word;
    logic [CNT_W-1:0]      rx_cnt_reg;
    logic [WORD_BITS-1:0]  rx_buf_reg;
    logic                  rx_flag_reg;
    logic                  rx_done;
    logic                  rx_accept;
    logic                  rx_ovr;
    logic                  rx_read;
    logic [WORD_BITS-1:0]  hold_reg;
    logic                  hold_full_reg;
    logic [WORD_BITS-1:0]  tsr_reg;
    logic [CNT_W-1:0]      tx_cnt_reg;
    uss_tx_state_t         tx_state_reg;
    logic                  tx_xfer;
    logic                  tx_write;
    logic                  tx_empty_flag;
    logic                  oe_n_reg;
    logic                  wake_reg;
    logic                  aw_got_reg;
    logic                  w_got_reg;
    logic [ADDR_W-1:0]     awaddr_reg;
    logic [DATA_W-1:0]     wdata_reg;
    logic [3:0]            wstrb_reg;
    logic                  bvalid_reg;
    logic [1:0]            bresp_reg;
    logic                  rvalid_reg;
    logic [1:0]            rresp_reg;
    logic [DATA_W-1:0]     rdata_reg;
    logic [DATA_W-1:0]     rd_data;
    logic                  do_write;
    logic                  ar_hs;
    logic                  wr_lane;

    // pins pass two flip-flops
    uss_sync #(.W(3)) u_sync (
        .clk   (aclk),
        .rst_n (aresetn),
        .d     ({sys_sleep, serial_clock_line, serial_data_line_in}),
        .q     ({sleep_s, sck_s, sdi_s})
    );

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= sck_s;
        end
    end

    // R3 external clock edges only
    assign sck_fall = sck_prev_reg & ~sck_s;

    // R1 slave mode keeps running in sleep
    // R2 other modes never shift here
    assign mode_slave = ctrl_reg[CTRL_SPEN] & ctrl_reg[CTRL_SYNC] & ctrl_reg[CTRL_SLAVE];
    assign rx_on      = mode_slave & ctrl_reg[CTRL_CREN];
    assign tx_on      = mode_slave & ctrl_reg[CTRL_TXEN] & ~ctrl_reg[CTRL_CREN];

    // axi write channel
    assign s_axi_awready = ~aw_got_reg & ~bvalid_reg;
    assign s_axi_wready  = ~w_got_reg & ~bvalid_reg;
    assign do_write      = aw_got_reg & w_got_reg & ~bvalid_reg;
    assign wr_lane       = do_write & wstrb_reg[0];
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg <= 1'b0;
            awaddr_reg <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
        end else if (do_write) begin
            aw_got_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg <= 1'b0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg <= 1'b1;
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
        end else if (do_write) begin
            w_got_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= reg_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg   <= CTRL_RESET;
            irq_en_reg <= EV_RESET;
        end else if (wr_lane && reg_hit(awaddr_reg, OFF_CTRL)) begin
            ctrl_reg <= wdata_reg[CTRL_W-1:0];
        end else if (wr_lane && reg_hit(awaddr_reg, OFF_IRQ_EN)) begin
            irq_en_reg <= wdata_reg[EV_W-1:0];
        end
    end

    // axi read channel
    assign s_axi_arready = ~rvalid_reg;
    assign ar_hs         = s_axi_arvalid & ~rvalid_reg;
    assign rx_read       = ar_hs & reg_hit(s_axi_araddr, OFF_RXDATA);
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (reg_hit(s_axi_araddr, OFF_CTRL)) begin
            rd_data[CTRL_W-1:0] = ctrl_reg;
        end else if (reg_hit(s_axi_araddr, OFF_RXDATA)) begin
            rd_data[WORD_BITS-1:0] = rx_buf_reg;
        end else if (reg_hit(s_axi_araddr, OFF_STATUS)) begin
            rd_data[ST_RX_COMPLETE_FLAG]   = rx_flag_reg;
            rd_data[ST_TX_BUFFER_EMPTY_FLAG]   = tx_empty_flag;
            rd_data[ST_OVR]    = irq_stat_reg[EV_OVR];
            rd_data[ST_BUSY]   = (tx_state_reg == USS_TX_SHIFT);
            rd_data[ST_SLEEP]  = sleep_s;
            rd_data[ST_ACTIVE] = mode_slave;
        end else if (reg_hit(s_axi_araddr, OFF_IRQ_STAT)) begin
            rd_data[EV_W-1:0] = irq_stat_reg;
        end else if (reg_hit(s_axi_araddr, OFF_IRQ_EN)) begin
            rd_data[EV_W-1:0] = irq_en_reg;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rresp_reg  <= RESP_OKAY;
            rdata_reg  <= 32'h0000_0000;
        end else if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= reg_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= rd_data;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // receive shifter
    assign rx_word   = {sdi_s, rx_shift_reg[WORD_BITS-1:1]};
    assign rx_done   = rx_on & sck_fall & (rx_cnt_reg == LAST_BIT);
    assign rx_accept = rx_done & (~rx_flag_reg | rx_read);
    assign rx_ovr    = rx_done & ~rx_accept;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_shift_reg <= 8'h00;
            rx_cnt_reg   <= 3'h0;
        end else if (!rx_on) begin
            rx_cnt_reg <= 3'h0;
        // R7 data sampled from the line
        end else if (sck_fall) begin
            rx_shift_reg <= rx_word;
            rx_cnt_reg   <= rx_cnt_reg + 3'h1;
        end
    end

    // R8 word complete sets the flag
    // R16 set wins over the read clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_buf_reg  <= 8'h00;
            rx_flag_reg <= 1'b0;
        end else if (rx_accept) begin
            rx_buf_reg  <= rx_word;
            rx_flag_reg <= 1'b1;
        end else if (rx_read) begin
            rx_flag_reg <= 1'b0;
        end
    end

    // transmit holding buffer
    assign tx_write      = wr_lane & reg_hit(awaddr_reg, OFF_TXDATA);
    // R14 flag follows enable and empty buffer
    assign tx_empty_flag = ctrl_reg[CTRL_TXEN] & ~hold_full_reg;
    assign tx_xfer       = hold_full_reg & mode_slave & ctrl_reg[CTRL_TXEN] &
                           ((tx_state_reg == USS_TX_IDLE) ||
                            (tx_on && sck_fall && tx_cnt_reg == LAST_BIT));

    // R13 write refills buffer, clearing the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold_reg      <= 8'h00;
            hold_full_reg <= 1'b0;
        end else if (tx_write) begin
            hold_reg      <= wdata_reg[WORD_BITS-1:0];
            hold_full_reg <= 1'b1;
        end else if (tx_xfer) begin
            hold_full_reg <= 1'b0;
        end
    end

    // R12 reload shifter after last bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tsr_reg      <= 8'h00;
            tx_cnt_reg   <= 3'h0;
            tx_state_reg <= USS_TX_IDLE;
        end else if (tx_xfer) begin
            tsr_reg      <= hold_reg;
            tx_cnt_reg   <= 3'h0;
            tx_state_reg <= USS_TX_SHIFT;
        end else begin
            unique case (tx_state_reg)
                USS_TX_IDLE: begin
                    tx_cnt_reg <= 3'h0;
                end
                USS_TX_SHIFT: begin
                    if (!mode_slave || !ctrl_reg[CTRL_TXEN]) begin
                        tx_state_reg <= USS_TX_IDLE;
                    // R3 shifted by the master's clock
                    end else if (tx_on && sck_fall) begin
                        tsr_reg    <= {1'b0, tsr_reg[WORD_BITS-1:1]};
                        tx_cnt_reg <= tx_cnt_reg + 3'h1;
                        if (tx_cnt_reg == LAST_BIT) begin
                            tx_state_reg <= USS_TX_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // R11 drive data while shifting out
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oe_n_reg <= 1'b1;
        end else begin
            oe_n_reg <= ~(tx_on && tx_state_reg == USS_TX_SHIFT);
        end
    end

    assign serial_data_line_out  = tsr_reg[0];
    assign serial_data_line_oe_n = oe_n_reg;

    // sticky events, write-one clear, set wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_reg <= EV_RESET;
        end else begin
            irq_stat_reg <= (irq_stat_reg &
                             ~((wr_lane && reg_hit(awaddr_reg, OFF_IRQ_CLR)) ?
                               wdata_reg[EV_W-1:0] : EV_RESET)) |
                            {rx_ovr, tx_xfer, rx_accept};
        end
    end

    assign irq = |(irq_stat_reg & irq_en_reg);

    // R15 wake from flags and enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_reg <= 1'b0;
        end else begin
            wake_reg <= ctrl_reg[CTRL_PERIPHERAL_IRQ_ENABLE] &
                        ((rx_flag_reg & irq_en_reg[EV_RX]) |
                         (tx_empty_flag & irq_en_reg[EV_TX]));
        end
    end

    assign wake_req = wake_reg;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_idle_off;
        !mode_slave |=> (rx_cnt_reg == 3'h0) && oe_n_reg;
    endproperty
    a_idle_off: assert property (p_idle_off) // R2
        else $error("shifting outside slave mode");

    property p_sleep_rx;
        sleep_s && rx_on && sck_fall |=> rx_cnt_reg == 3'($past(rx_cnt_reg) + 3'h1);
    endproperty
    a_sleep_rx: assert property (p_sleep_rx) // R1
        else $error("receiver stalled in sleep");

    property p_ext_clock;
        rx_on && !sck_fall |=> $stable(rx_cnt_reg) && $stable(rx_shift_reg);
    endproperty
    a_ext_clock: assert property (p_ext_clock) // R3
        else $error("shift without link clock edge");

    property p_rx_sample;
        rx_on && sck_fall |=> rx_shift_reg[WORD_BITS-1] == $past(sdi_s);
    endproperty
    a_rx_sample: assert property (p_rx_sample) // R7
        else $error("data line not sampled");

    property p_rx_flag;
        rx_done && !rx_flag_reg |=> rx_flag_reg && (rx_buf_reg == $past(rx_word));
    endproperty
    a_rx_flag: assert property (p_rx_flag) // R8
        else $error("word did not set receive flag");

    property p_tx_drive;
        tx_on && tx_state_reg == USS_TX_SHIFT |=> !serial_data_line_oe_n;
    endproperty
    a_tx_drive: assert property (p_tx_drive) // R11
        else $error("data line not driven");

    property p_tx_reload;
        tx_on && tx_state_reg == USS_TX_SHIFT && sck_fall && tx_cnt_reg == LAST_BIT &&
        hold_full_reg && !tx_write |=> tsr_reg == $past(hold_reg) && tx_empty_flag;
    endproperty
    a_tx_reload: assert property (p_tx_reload) // R12
        else $error("buffer not moved to shifter");

    property p_tx_write;
        tx_write && ctrl_reg[CTRL_TXEN] |=> !tx_empty_flag ##1 hold_full_reg || tx_empty_flag;
    endproperty
    a_tx_write: assert property (p_tx_write) // R13
        else $error("write did not clear transmit flag");

    property p_tx_flag_fall;
        $fell(tx_empty_flag) && $stable(ctrl_reg[CTRL_TXEN]) |-> $past(tx_write);
    endproperty
    a_tx_flag_fall: assert property (p_tx_flag_fall) // R14
        else $error("transmit flag cleared without a write");

    property p_wake;
        ctrl_reg[CTRL_PERIPHERAL_IRQ_ENABLE] && rx_flag_reg && irq_en_reg[EV_RX] |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) // R15
        else $error("no wake request");

    property p_no_loss;
        rx_flag_reg && !rx_read |=> rx_flag_reg;
    endproperty
    a_no_loss: assert property (p_no_loss) // R16
        else $error("receive flag lost");

    c_rx_sleep: cover property (sleep_s && rx_accept);
    c_tx_reload: cover property (sleep_s && tx_xfer && tx_state_reg == USS_TX_SHIFT);
    c_overrun: cover property (rx_ovr);
    c_wake: cover property (sleep_s && $rose(wake_req));
endmodule : uss_top

`default_nettype wire

// File: testbench/uss_link_master.sv
// external synchronous master: drives the shift clock and its data bits
// assumes the bench resolves the shared data wire and feeds it back
`timescale 1ns/1ns
`default_nettype none

module uss_link_master (
    output logic      serial_clock_line,
    output logic      master_data,
    input  wire logic wire_level
);
    localparam int HALF_NS = 400;

    initial begin
        serial_clock_line = 1'b0;
        master_data       = 1'b1;
    end

    task automatic frame(input logic [7:0] tx_byte, output logic [7:0] rx_byte);
        for (int i = 0; i < 8; i++) begin
            serial_clock_line = 1'b1;
            rx_byte[i]        = wire_level;
            master_data       = tx_byte[i];
            #HALF_NS;
            serial_clock_line = 1'b0;
            #HALF_NS;
        end
        // released line shows the inverse
        master_data = ~master_data;
    endtask : frame
endmodule : uss_link_master

`default_nettype wire

// File: testbench/tb_usart_sync_slave_sleep.sv
// self-checking bench: register sequences over axi4-lite, frames from the master
// assumes the link master model and the design top in the same build
`timescale 1ns/1ns
`default_nettype none

module tb_usart_sync_slave_sleep
    import uss_pkg::*;
;
    logic              aclk = 1'b0;
    logic              aresetn = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, rd;
    logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic              arvalid = 1'b0, rready = 1'b0, sys_sleep = 1'b0;
    logic              awready, wready, bvalid, arready, rvalid;
    logic [1:0]        bresp, rresp, resp;
    logic              sclk, mdata, dout, oe_n, wake_req, irq, wire_level;
    logic [7:0]        got;
    int                bad_count = 0;
    int                n_checks = 0;

    always #50 aclk = ~aclk;
    assign wire_level = oe_n ? mdata : dout;

    uss_top u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sys_sleep(sys_sleep),
        .serial_clock_line(sclk), .serial_data_line_in(wire_level),
        .serial_data_line_out(dout), .serial_data_line_oe_n(oe_n),
        .wake_req(wake_req), .irq(irq)
    );

    uss_link_master u_master (
        .serial_clock_line(sclk), .master_data(mdata), .wire_level(wire_level)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic axi_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_write

    task automatic axi_read(input logic [ADDR_W-1:0] a);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_read

    task automatic wait_wake;
        for (int i = 0; i < 40 && wake_req !== 1'b1; i++) @(posedge aclk);
    endtask : wait_wake

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run

    initial begin
        #2_000_000;
        bad_count++;
        complete_run();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi_read(OFF_STATUS);
        check(rd, 32'h0000_0000);
        axi_read(8'h40);
        check({rd[29:0], resp}, {30'h0, RESP_SLVERR});
        // slave reception in sleep
        axi_write(OFF_CTRL, 32'h0000_0037);
        axi_write(OFF_IRQ_EN, 32'h0000_0001);
        axi_read(OFF_RXDATA);
        sys_sleep <= 1'b1;
        #37;
        u_master.frame(8'hA5, got);
        wait_wake();
        check(wake_req, 1'b1);
        check(oe_n, 1'b1);
        @(posedge aclk);
        sys_sleep <= 1'b0;
        axi_read(OFF_STATUS);
        check(rd[0], 1'b1);
        check(irq, 1'b1);
        axi_read(OFF_RXDATA);
        check(rd, 32'h0000_00A5);
        axi_read(OFF_STATUS);
        check({rd[0], wake_req}, 2'b00);
        axi_write(OFF_IRQ_CLR, 32'h0000_0007);
        check(irq, 1'b0);
        // not slave: nothing shifts
        axi_write(OFF_CTRL, 32'h0000_0013);
        #37;
        u_master.frame(8'h5A, got);
        repeat (10) @(posedge aclk);
        axi_read(OFF_IRQ_STAT);
        check(rd, 32'h0000_0000);
        // second word while the first is unread
        axi_write(OFF_CTRL, 32'h0000_0037);
        #37;
        u_master.frame(8'h11, got);
        #37;
        u_master.frame(8'h22, got);
        repeat (4) @(posedge aclk);
        axi_read(OFF_STATUS);
        check(rd[2:0], 3'b101);
        axi_read(OFF_RXDATA);
        check(rd, 32'h0000_0011);
        // slave transmission in sleep
        axi_write(OFF_CTRL, 32'h0000_002F);
        axi_write(OFF_IRQ_EN, 32'h0000_0002);
        axi_write(OFF_TXDATA, 32'h0000_003C);
        axi_write(OFF_TXDATA, 32'h0000_0096);
        axi_read(OFF_STATUS);
        check({rd[3], rd[1]}, 2'b10);
        check({oe_n, wake_req}, 2'b00);
        sys_sleep <= 1'b1;
        #37;
        u_master.frame(8'h00, got);
        check(got, 8'h3C);
        wait_wake();
        check({wake_req, irq}, 2'b11);
        axi_write(OFF_STATUS, 32'h0000_0000);
        check(resp, RESP_OKAY);
        axi_read(OFF_STATUS);
        check(rd[1], 1'b1);
        #37;
        u_master.frame(8'h00, got);
        check(got, 8'h96);
        complete_run();
    end
endmodule : tb_usart_sync_slave_sleep

`default_nettype wire
